// *** common/ifcu_pkg.sv ***
// Shared constants and state carriers for the flash update command unit.
// Assumes one 25 MHz system clock; every timing count derives from it here.
package ifcu_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int BUS_RATE_HZ = 100_000;
  localparam int TCK_HZ = 23_440;
  localparam int TCK_DIV = (SYS_CLK_HZ + TCK_HZ / 2) / TCK_HZ;
  // One blink step is 10 ms, i.e. 100 steps per second
  localparam int BLINK_STEPS_PER_S = 100;

  // ****************************************
  // Bus and packet codes
  // ****************************************
  localparam logic [7:0] LOCAL_ADDR_BYTE = 8'hA0;
  localparam logic [7:0] LEAD_CODE = 8'h01;
  localparam logic [7:0] CMD_INIT = 8'h02;
  localparam logic [7:0] CMD_WRITE = 8'h03;
  localparam logic [7:0] CMD_END = 8'h04;
  localparam logic [15:0] LEN_INIT = 16'h0002;
  localparam logic [15:0] LEN_WRITE = 16'h0006;
  localparam logic [15:0] LEN_END = 16'h0002;
  localparam logic [15:0] LEN_OVERHEAD = 16'h0002;

  // ****************************************
  // Flash layout and reset values
  // ****************************************
  localparam logic [15:0] WRITE_ADDR = 16'h3BFC;
  localparam logic [15:0] BLOCK_SIZE = 16'h0400;
  localparam logic [5:0] SHIELD_FIRST = 6'h00;
  localparam logic [5:0] SHIELD_LAST = 6'h0F;
  localparam logic [5:0] SHIELD_START_RST = 6'h00;
  localparam logic [5:0] SHIELD_END_RST = 6'h0F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [31:0] STORE_RST = 32'hFFFFFFFF;

  // ****************************************
  // States and carriers
  // ****************************************
  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_ADDR = 3'h1, I_ACK = 3'h3, I_WAIT = 3'h2, I_DATA = 3'h6
  } ifcu_bus_state_type;

  typedef enum logic [3:0] {
    X_RELOAD = 4'h0, P_LEAD = 4'h1, P_LEN_HI = 4'h3, P_LEN_LO = 4'h2,
    P_CMD = 4'h6, P_DATA = 4'h7, P_SUM = 4'h5, X_INIT = 4'h4,
    X_SHIELD = 4'hC, X_BLANK = 4'hD, X_ERASE = 4'hF, X_PROG = 4'hE,
    X_VERIFY = 4'hA, P_HALT = 4'hB
  } ifcu_proc_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } ifcu_byte_type;

  typedef struct packed {
    ifcu_bus_state_type ist;
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic addr_phase, dir_read;
    logic scl_oe, sda_oe, scl_out, sda_out;
    ifcu_byte_type push;
    ifcu_proc_state_type pst;
    logic [15:0] len, remain;
    logic [7:0] cmd, csum;
    logic [2:0] didx;
    logic [3:0][7:0] rx, store;
    logic [5:0] sh_start, sh_end, blk;
    logic env_open;
    logic blink_lamp_port, access_lamp_port, halted, idle_wait, tmr_run;
    logic [10:0] div;
    logic [19:0] ivl, cnt;
  } ifcu_state_type;

endpackage : ifcu_pkg

// *** rtl/ifcu_top.sv ***
// Serial-bus slave that takes flash update packets and drives two lamps.
// Assumes an external open-drain resolver on the pins and a 25 MHz sys_clk.
`timescale 1ns/1ps

// ****************************************
// Byte FIFO
// ****************************************
module ifcu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp, rp;
  } ifcu_fifo_state_type;

  ifcu_fifo_state_type s, next_s;
  logic [AW:0] fill;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("ifcu_fifo: DEPTH must be a power of two >= 2");
  end

  assign fill = s.wp - s.rp;
  assign in_ready = fill != (AW + 1)'(DEPTH);
  assign out_valid = s.wp != s.rp;
  assign out_data = s.mem[s.rp[AW-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      next_s.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : ifcu_fifo

// ****************************************
// Command unit
// ****************************************
module ifcu_top #(
  parameter int FIFO_DEPTH = 32,
  parameter logic [31:0] STORE_INIT = ifcu_pkg::STORE_RST,
  parameter logic [5:0] SHIELD_START_INIT = ifcu_pkg::SHIELD_START_RST,
  parameter logic [5:0] SHIELD_END_INIT = ifcu_pkg::SHIELD_END_RST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Serial data pin
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Flash fault from the programming engine
  input wire logic flash_fail_force,
  // Lamps (low lights) and status
  output logic blink_lamp_port,
  output logic access_lamp_port,
  output logic halted,
  output logic idle_wait,
  output logic timer_running
);
  ifcu_pkg::ifcu_state_type s, next_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, listening, fail;
  logic [7:0] fifo_out_data, b;
  logic [9:0] sum;
  logic [19:0] ivl_calc;
  logic [5:0] target_blk;

  if (ifcu_pkg::SYS_CLK_HZ < 20 * ifcu_pkg::BUS_RATE_HZ) begin : g_chk
    $error("ifcu_top: system clock too slow to oversample the bus");
  end

  ifcu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(s.push.valid),
    .in_data(s.push.data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(listening)
  );

  // ****************************************
  // Derived terms
  // ****************************************
  // Bus edges use the second sync stage against its delayed copy
  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign bus_start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign bus_stop = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
  assign listening = (s.pst == ifcu_pkg::P_LEAD) || (s.pst == ifcu_pkg::P_LEN_HI) ||
                     (s.pst == ifcu_pkg::P_LEN_LO) || (s.pst == ifcu_pkg::P_CMD) ||
                     (s.pst == ifcu_pkg::P_DATA) || (s.pst == ifcu_pkg::P_SUM);
  assign fifo_pop = fifo_out_valid && listening;
  assign b = fifo_out_data;
  assign sum = 10'(s.store[0]) + 10'(s.store[1]) + 10'(s.store[2]) + 10'(s.store[3]);
  // Average times 10 ms in prescaled ticks: sum/4 * TCK_HZ/100
  assign ivl_calc = 20'((32'(sum) * 32'(ifcu_pkg::TCK_HZ)) /
                        32'(4 * ifcu_pkg::BLINK_STEPS_PER_S));
  assign target_blk = 6'(ifcu_pkg::WRITE_ADDR / ifcu_pkg::BLOCK_SIZE);

  always_comb begin
    next_s = s;
    fail = 1'b0;
    next_s.push.valid = 1'b0;
    next_s.scl_s1 = serial_clock_pin_in;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d = s.scl_s2;
    next_s.sda_s1 = serial_data_pin_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d = s.sda_s2;

    // ****************************************
    // Prescaler and blink timer
    // ****************************************
    // Prescaler runs free; the interval counter only while started
    if (s.div == 11'(ifcu_pkg::TCK_DIV - 1)) begin
      next_s.div = '0;
      if (s.tmr_run) begin
        if (s.cnt + 20'd1 >= s.ivl) begin
          next_s.cnt = '0;
          next_s.blink_lamp_port = ~s.blink_lamp_port;
        end else begin
          next_s.cnt = s.cnt + 20'd1;
        end
      end
    end else begin
      next_s.div = s.div + 11'd1;
    end

    // ****************************************
    // Bus slave
    // ****************************************
    // Once halted the bus stays frozen in its current wait
    if (!s.halted) begin
      if (bus_stop) begin
        next_s.ist = ifcu_pkg::I_IDLE;
        next_s.sda_oe = 1'b0;
      end else if (bus_start) begin
        next_s.ist = ifcu_pkg::I_ADDR;
        next_s.bitcnt = '0;
        next_s.sda_oe = 1'b0;
      end else begin
        case (s.ist)
          ifcu_pkg::I_ADDR, ifcu_pkg::I_DATA: begin
            if (scl_rise) begin
              next_s.shreg = {s.shreg[6:0], s.sda_s2};
              next_s.bitcnt = s.bitcnt + 4'd1;
            end else if (scl_fall && s.bitcnt == 4'd8) begin
              if (s.ist == ifcu_pkg::I_DATA ||
                  s.shreg[7:1] == ifcu_pkg::LOCAL_ADDR_BYTE[7:1]) begin
                next_s.sda_oe = 1'b1;
                next_s.addr_phase = s.ist == ifcu_pkg::I_ADDR;
                next_s.ist = ifcu_pkg::I_ACK;
              end else begin
                next_s.ist = ifcu_pkg::I_IDLE;
              end
            end
          end
          ifcu_pkg::I_ACK: begin
            // Ninth falling edge: byte event, then hold the clock low
            if (scl_fall) begin
              next_s.sda_oe = 1'b0;
              next_s.scl_oe = 1'b1;
              next_s.ist = ifcu_pkg::I_WAIT;
              if (s.addr_phase) begin
                next_s.dir_read = s.shreg[0];
                next_s.tmr_run = 1'b0;
              end else begin
                next_s.push.valid = 1'b1;
                next_s.push.data = s.shreg;
              end
            end
          end
          ifcu_pkg::I_WAIT: begin
            if (s.addr_phase && s.dir_read) begin
              next_s.halted = 1'b1;
              next_s.blink_lamp_port = 1'b0;
              next_s.access_lamp_port = 1'b0;
            end else if (s.addr_phase ||
                         (!s.push.valid && !fifo_out_valid && fifo_in_ready &&
                          listening)) begin
              // Release at once after the address byte; after a data byte only once every byte is consumed and no command runs
              next_s.scl_oe = 1'b0;
              next_s.bitcnt = '0;
              next_s.ist = ifcu_pkg::I_DATA;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // ****************************************
    // Packet parser and flash steps
    // ****************************************
    if (fifo_pop) begin
      case (s.pst)
        ifcu_pkg::P_LEAD: begin
          if (b == ifcu_pkg::LEAD_CODE) begin
            next_s.pst = ifcu_pkg::P_LEN_HI;
          end else begin
            fail = 1'b1;
          end
        end
        ifcu_pkg::P_LEN_HI: begin
          next_s.len[15:8] = b;
          next_s.pst = ifcu_pkg::P_LEN_LO;
        end
        ifcu_pkg::P_LEN_LO: begin
          next_s.len[7:0] = b;
          next_s.pst = ifcu_pkg::P_CMD;
        end
        ifcu_pkg::P_CMD: begin
          next_s.cmd = b;
          next_s.csum = b;
          next_s.didx = '0;
          next_s.remain = s.len - ifcu_pkg::LEN_OVERHEAD;
          if (s.len < ifcu_pkg::LEN_OVERHEAD) begin
            fail = 1'b1;
          end else if (s.len == ifcu_pkg::LEN_OVERHEAD) begin
            next_s.pst = ifcu_pkg::P_SUM;
          end else begin
            next_s.pst = ifcu_pkg::P_DATA;
          end
        end
        ifcu_pkg::P_DATA: begin
          if (s.didx < 3'd4) begin
            next_s.rx[s.didx[1:0]] = b;
          end
          next_s.didx = (s.didx == 3'd7) ? s.didx : s.didx + 3'd1;
          next_s.csum = s.csum + b;
          next_s.remain = s.remain - 16'd1;
          if (s.remain == 16'd1) begin
            next_s.pst = ifcu_pkg::P_SUM;
          end
        end
        ifcu_pkg::P_SUM: begin
          if (b != s.csum) begin
            fail = 1'b1;
          end else if (s.cmd == ifcu_pkg::CMD_INIT && s.len == ifcu_pkg::LEN_INIT) begin
            next_s.access_lamp_port = 1'b0;
            next_s.pst = ifcu_pkg::X_INIT;
          end else if (s.cmd == ifcu_pkg::CMD_WRITE && s.len == ifcu_pkg::LEN_WRITE &&
                       s.env_open) begin
            next_s.pst = ifcu_pkg::X_BLANK;
          end else if (s.cmd == ifcu_pkg::CMD_END && s.len == ifcu_pkg::LEN_END &&
                       s.env_open) begin
            next_s.pst = ifcu_pkg::X_VERIFY;
          end else begin
            fail = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else begin
      // Bus stays stretched through execution states entered from a packet; the X_RELOAD after reset runs with the bus idle
      case (s.pst)
        ifcu_pkg::X_INIT: begin
          if (flash_fail_force) begin
            fail = 1'b1;
          end else begin
            next_s.env_open = 1'b1;
            if (s.sh_start != ifcu_pkg::SHIELD_FIRST || s.sh_end != ifcu_pkg::SHIELD_LAST) begin
              next_s.pst = ifcu_pkg::X_SHIELD;
            end else begin
              next_s.pst = ifcu_pkg::P_LEAD;
            end
          end
        end
        ifcu_pkg::X_SHIELD: begin
          next_s.sh_start = ifcu_pkg::SHIELD_FIRST;
          next_s.sh_end = ifcu_pkg::SHIELD_LAST;
          next_s.pst = ifcu_pkg::P_LEAD;
        end
        ifcu_pkg::X_BLANK: begin
          next_s.blk = target_blk;
          if (flash_fail_force || target_blk < s.sh_start || target_blk > s.sh_end) begin
            fail = 1'b1;
          end else if (s.store == {4{ifcu_pkg::ERASED_BYTE}}) begin
            next_s.pst = ifcu_pkg::X_PROG;
          end else begin
            next_s.pst = ifcu_pkg::X_ERASE;
          end
        end
        ifcu_pkg::X_ERASE: begin
          if (flash_fail_force) begin
            fail = 1'b1;
          end else begin
            next_s.store = {4{ifcu_pkg::ERASED_BYTE}};
            next_s.pst = ifcu_pkg::X_PROG;
          end
        end
        ifcu_pkg::X_PROG: begin
          if (flash_fail_force) begin
            fail = 1'b1;
          end else begin
            next_s.store = s.rx;
            next_s.pst = ifcu_pkg::P_LEAD;
          end
        end
        ifcu_pkg::X_VERIFY: begin
          if (flash_fail_force || s.store != s.rx) begin
            fail = 1'b1;
          end else begin
            next_s.access_lamp_port = 1'b1;
            next_s.pst = ifcu_pkg::X_RELOAD;
          end
        end
        ifcu_pkg::X_RELOAD: begin
          // Start-up and post-update share this load of the interval
          next_s.blink_lamp_port = 1'b0;
          next_s.ivl = ivl_calc;
          next_s.cnt = '0;
          next_s.tmr_run = sum != 10'd0;
          next_s.pst = ifcu_pkg::P_LEAD;
        end
        default: begin
        end
      endcase
    end

    if (fail) begin
      next_s.halted = 1'b1;
      next_s.blink_lamp_port = 1'b0;
      next_s.access_lamp_port = 1'b0;
      next_s.tmr_run = 1'b0;
      next_s.pst = ifcu_pkg::P_HALT;
    end
    // Timer ticks never clear this; a bus start condition does
    next_s.idle_wait = next_s.ist == ifcu_pkg::I_IDLE && next_s.pst == ifcu_pkg::P_LEAD &&
                       !next_s.halted;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ist <= ifcu_pkg::I_IDLE;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_d <= 1'b1;
      s.pst <= ifcu_pkg::X_RELOAD;
      s.store <= STORE_INIT;
      s.sh_start <= SHIELD_START_INIT;
      s.sh_end <= SHIELD_END_INIT;
      s.blink_lamp_port <= 1'b1;
      s.access_lamp_port <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_clock_pin_out = s.scl_out;
  assign serial_clock_pin_oe = s.scl_oe;
  assign serial_data_pin_out = s.sda_out;
  assign serial_data_pin_oe = s.sda_oe;
  assign blink_lamp_port = s.blink_lamp_port;
  assign access_lamp_port = s.access_lamp_port;
  assign halted = s.halted;
  assign idle_wait = s.idle_wait;
  assign timer_running = s.tmr_run;
endmodule : ifcu_top

// *** verif/ifcu_asserts.sv ***
// Checker for the flash update command unit, on the top-level ports only.
// Assumes the single sys_clk domain and asynchronous active-high rst.
`timescale 1ns/1ps
module ifcu_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial pins
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  // Lamps and status
  input wire logic blink_lamp_port,
  input wire logic access_lamp_port,
  input wire logic halted,
  input wire logic idle_wait,
  input wire logic timer_running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Byte hand-off, pins, halt, lamps and timer
  // ****************************************
  sequence ack_ends;
    $fell(serial_data_pin_oe);
  endsequence
  sequence bus_held;
    serial_clock_pin_oe;
  endsequence

  AST_OPEN_DRAIN: assert property (!serial_clock_pin_out && !serial_data_pin_out)
    else $error("pin output level not low");
  AST_ACK_THEN_WAIT: assert property (ack_ends |-> bus_held)
    else $error("no wait after acknowledge");
  AST_HALT_STICKY: assert property (halted |=> halted)
    else $error("halt released without reset");
  AST_HALT_LAMPS: assert property (halted |=> !blink_lamp_port && !access_lamp_port)
    else $error("lamps not both lit while halted");
  AST_HALT_HOLDS_BUS: assert property (halted |=> bus_held)
    else $error("bus wait dropped while halted");
  AST_IDLE_NO_STRETCH: assert property (idle_wait |-> !serial_clock_pin_oe)
    else $error("clock held during idle wait");
  AST_TIMER_AFTER_ACCESS: assert property ($rose(timer_running) |-> access_lamp_port)
    else $error("timer started while flash busy");
  AST_ACCESS_LIT_HELD: assert property ($fell(access_lamp_port) |-> bus_held)
    else $error("access lamp lit without bus wait");
endmodule : ifcu_asserts

bind ifcu_top ifcu_asserts u_asserts (
  .sys_clk(sys_clk),
  .rst(rst),
  .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe),
  .blink_lamp_port(blink_lamp_port),
  .access_lamp_port(access_lamp_port),
  .halted(halted),
  .idle_wait(idle_wait),
  .timer_running(timer_running)
);

// *** verif/ifcu_master.sv ***
// Behavioural serial bus master that sends update packets.
// Assumes pulled-up wires resolved by the bench; waits out clock stretching.
`timescale 1ns/1ps
module ifcu_master (
  // Clock
  input wire logic sys_clk,
  // Resolved wires
  input wire logic scl_wire,
  input wire logic sda_wire,
  // Pull-down enables
  output logic scl_oe,
  output logic sda_oe
);
  localparam int HALF = 125;
  localparam int STRETCH_MAX = 4000;
  int n_stuck;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    n_stuck = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  // Waits for the slave to let the clock go, but never forever
  task automatic rise_scl;
    int k;
    k = 0;
    scl_oe = 1'b0;
    tick(1);
    while (scl_wire !== 1'b1 && k < STRETCH_MAX) begin
      tick(1);
      k++;
    end
    if (k >= STRETCH_MAX) n_stuck++;
    tick(HALF);
  endtask : rise_scl

  task automatic idle;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  endtask : idle

  task automatic start;
    sda_oe = 1'b0;
    rise_scl();
    sda_oe = 1'b1;
    tick(HALF);
    scl_oe = 1'b1;
  endtask : start

  task automatic bit_out(input logic b);
    tick(HALF / 2);
    sda_oe = !b;
    tick(HALF / 2);
    rise_scl();
    scl_oe = 1'b1;
  endtask : bit_out

  task automatic wr(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    tick(HALF / 2);
    sda_oe = 1'b0;
    tick(HALF / 2);
    rise_scl();
    ack = !sda_wire;
    scl_oe = 1'b1;
  endtask : wr

  task automatic stop;
    tick(HALF / 2);
    sda_oe = 1'b1;
    tick(HALF / 2);
    rise_scl();
    sda_oe = 1'b0;
    tick(HALF);
  endtask : stop
endmodule : ifcu_master

// *** verif/tb_ifcu_top.sv ***
// Self-checking bench: update packets through the serial master model.
// Assumes 25 MHz sys_clk and a stored start-up value of four ones.
`timescale 1ns/1ps
module tb_ifcu_top;
  logic sys_clk, rst, flash_fail_force, ack;
  logic scl_oe_dut, sda_oe_dut, m_scl_oe, m_sda_oe;
  logic blink_lamp_port, access_lamp_port, halted, idle_wait, timer_running;
  wire logic scl_wire;
  wire logic sda_wire;
  int n_mismatch, compares, cyc;

  // Pull-ups on both wires
  assign scl_wire = !(scl_oe_dut || m_scl_oe);
  assign sda_wire = !(sda_oe_dut || m_sda_oe);

  ifcu_master m (.sys_clk(sys_clk), .scl_wire(scl_wire), .sda_wire(sda_wire),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  // Window end below the target block: the write only passes if init widens it
  ifcu_top #(.STORE_INIT(32'h01010101), .SHIELD_END_INIT(6'h05)) dut (.sys_clk(sys_clk), .rst(rst),
    .serial_clock_pin_in(scl_wire), .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe_dut),
    .serial_data_pin_in(sda_wire), .serial_data_pin_out(), .serial_data_pin_oe(sda_oe_dut),
    .flash_fail_force(flash_fail_force), .blink_lamp_port(blink_lamp_port),
    .access_lamp_port(access_lamp_port), .halted(halted), .idle_wait(idle_wait),
    .timer_running(timer_running));

  initial sys_clk = 1'b0;
  always #20 sys_clk = !sys_clk;

  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cyc++;
    // Tests need about 85k cycles; the rest is margin for stretched bytes
    if (cyc == 95000) begin
      n_mismatch++;
      $display("mismatch at %0t: run too long", $time);
      print_verdict();
    end
  end

  task automatic do_reset;
    @(negedge sys_clk);
    m.idle();
    rst = 1'b1;
    flash_fail_force = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask : do_reset

  task automatic wr_ack(input logic [7:0] v);
    m.wr(v, ack);
    chk(ack, 1'b1, "byte not acknowledged");
  endtask : wr_ack

  // Packet: lead, length, command, data, checksum
  task automatic send_pkt(input logic [7:0] cmd, input logic [7:0] len_lo,
    input logic [31:0] d, input int nd, input logic [7:0] sum, input bit fin);
    m.start();
    wr_ack(ifcu_pkg::LOCAL_ADDR_BYTE);
    repeat (8) @(negedge sys_clk);
    chk(timer_running, 1'b0, "blink timer still running");
    wr_ack(ifcu_pkg::LEAD_CODE);
    wr_ack(8'h00);
    wr_ack(len_lo);
    wr_ack(cmd);
    for (int i = 0; i < nd; i++) wr_ack(d[31 - 8 * i -: 8]);
    wr_ack(sum);
    if (fin) m.stop();
    repeat (60) @(negedge sys_clk);
  endtask : send_pkt

  task automatic expect_ok(input logic acc, input string name);
    chk(halted, 1'b0, "unexpected halt");
    chk(m.n_stuck == 0, 1'b1, "bus wait never released");
    chk(access_lamp_port, acc, "access lamp state");
    $display("test %s done", name);
  endtask : expect_ok

  task automatic expect_halt(input string name);
    chk(halted, 1'b1, "not halted");
    chk(blink_lamp_port, 1'b0, "blink lamp not lit");
    chk(access_lamp_port, 1'b0, "access lamp not lit");
    chk(scl_oe_dut, 1'b1, "bus wait released");
    $display("test %s done", name);
  endtask : expect_halt

  initial begin
    rst = 1'b1;
    flash_fail_force = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    do_reset();
    chk(idle_wait, 1'b1, "not in idle wait");
    chk(timer_running, 1'b1, "blink timer not started");
    chk(blink_lamp_port, 1'b0, "blink lamp not lit");
    chk(access_lamp_port, 1'b1, "access lamp lit at start");
    $display("test reset done");
    m.start();
    m.wr(8'hB0, ack);
    chk(ack, 1'b0, "foreign address acknowledged");
    m.stop();
    repeat (20) @(negedge sys_clk);
    chk(timer_running, 1'b1, "timer stopped by foreign address");
    chk(idle_wait, 1'b1, "stop condition woke the unit");
    $display("test foreign done");
    // Init, write, end in the order the master must keep
    send_pkt(ifcu_pkg::CMD_INIT, 8'h02, 32'h0, 0, ifcu_pkg::CMD_INIT, 1'b1);
    expect_ok(1'b0, "init");
    send_pkt(ifcu_pkg::CMD_WRITE, 8'h06, 32'h10203040, 4, 8'hA3, 1'b1);
    expect_ok(1'b0, "write");
    send_pkt(ifcu_pkg::CMD_END, 8'h02, 32'h0, 0, ifcu_pkg::CMD_END, 1'b1);
    chk(timer_running, 1'b1, "blink timer not restarted");
    chk(blink_lamp_port, 1'b0, "blink lamp not lit at reload");
    expect_ok(1'b1, "end");
    do_reset();
    m.start();
    m.wr(8'hA1, ack);
    chk(ack, 1'b1, "read address not acknowledged");
    repeat (20) @(negedge sys_clk);
    expect_halt("read request");
    do_reset();
    send_pkt(ifcu_pkg::CMD_INIT, 8'h02, 32'h0, 0, 8'h55, 1'b0);
    expect_halt("bad checksum");
    do_reset();
    flash_fail_force = 1'b1;
    send_pkt(ifcu_pkg::CMD_INIT, 8'h02, 32'h0, 0, ifcu_pkg::CMD_INIT, 1'b0);
    expect_halt("flash fault");
    print_verdict();
  end
endmodule : tb_ifcu_top
